// file: rtl/interrupt_flag_and_option_bank.sv
// Interrupt flag and option register bank behind a classic Wishbone slave.
// Assumes all event inputs except lowVoltage come from logic on clk; lowVoltage is asynchronous.
// Functional notes
// RQ1: ADC select 00 divides clock by 32, 01 by 3, 11 by 4; reset 00.
// RQ2: With force-clear and mask enable high, negative PWM output follows negative mask level.
// RQ3: With force-clear and mask enable high, positive PWM output follows positive mask level.
// RQ4: Watchdog select 11 gives one overflow every 27 ms.
// RQ5: Low supply report sets the low-voltage flag, bit 7.
// RQ6: Writing 7Fh clears low-voltage flag, but only once supply is no longer low.
// RQ7: Finished memory write sets the write-done flag, bit 6.
// RQ8: Bit 5 is read-only and high while a memory write runs; reset 0.
// RQ9: End of each ADC conversion sets the ADC done flag, bit 4.
// RQ10: ADC done clears by writing EFh or by setting ADC start-conversion.
// RQ11: Enabled pin change on ports 0 to 3 sets pin-change flag, bit 1.
// RQ12: Writing 0 to pin-change flag also clears all per-pin and per-port flags.
// RQ13: Timer three reaching its selected count sets flag bit 0.
// RQ14: Watchdog select 00 gives 220 ms, 01 gives 110 ms, 10 gives 54 ms.
// RQ15: Entering the memory write interrupt routine clears the write-done flag.
// RQ16: Flag written 0 clears, written 1 holds; hardware set beats clear.
// RQ17: Flags are sticky levels to interrupt logic and always readable.
`timescale 1ns/1ns
`default_nettype none
module interrupt_flag_and_option_bank
  import irq_flag_option_pkg::*;
#(
  parameter int WDT_W        = 25,
  parameter int WDT_PER_220  = WDT_CYC_220,
  parameter int WDT_PER_110  = WDT_CYC_110,
  parameter int WDT_PER_54   = WDT_CYC_54,
  parameter int WDT_PER_27   = WDT_CYC_27
)
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire wb_req_t          wbReq,
  output logic                  wbAck,
  output logic [DAT_W-1:0]      wbDatO,
  input  wire flag_src_t        flagSrc,
  input  wire pwm_in_t          pwmIn,
  input  wire logic             wdtClear,
  output logic                  adcClkTick,
  output logic                  watchdogOverflow,
  output logic                  pwmPositiveOutput,
  output logic                  pwmNegativeOutput,
  output logic [REG_W-1:0]      interruptFlags,
  output logic                  pinFlagsClear
);

  // Every period must fit the counter and be at least two cycles
  if (WDT_PER_220 >= (1 << WDT_W) || WDT_PER_110 >= (1 << WDT_W) ||
      WDT_PER_54 >= (1 << WDT_W) || WDT_PER_27 >= (1 << WDT_W) ||
      WDT_PER_220 < 2 || WDT_PER_110 < 2 || WDT_PER_54 < 2 || WDT_PER_27 < 2)
  begin : g_bad_wdt
    $error("watchdog period does not fit WDT_W");
  end

  typedef struct packed {
    logic             ackQ;
    logic [DAT_W-1:0] datO;
    logic [REG_W-1:0] option;
    logic [REG_W-1:0] flags;
    logic             lvMeta;
    logic             lvSync;
    logic [4:0]       adcCnt;
    logic             adcTick;
    logic [WDT_W-1:0] wdtCnt;
    logic [1:0]       wdtSel;
    logic             wdtOvf;
    logic             pwmPos;
    logic             pwmNeg;
    logic             pinClr;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic isReg(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    isReg = (adr[ADR_W-1:2] == idx);
  endfunction

  function automatic logic [5:0] adcDivisor(input logic [1:0] sel);
    case (sel)
      ADC_SEL_3: adcDivisor = ADC_DIV_3;
      ADC_SEL_4: adcDivisor = ADC_DIV_4;
      // Code 10 is undefined; it falls back to the slowest rate
      default:   adcDivisor = ADC_DIV_32;
    endcase
  endfunction

  function automatic logic [WDT_W-1:0] wdtPeriod(input logic [1:0] sel);
    case (sel)
      WDT_SEL_110: wdtPeriod = WDT_W'(WDT_PER_110);
      WDT_SEL_54:  wdtPeriod = WDT_W'(WDT_PER_54);
      WDT_SEL_27:  wdtPeriod = WDT_W'(WDT_PER_27);
      default:     wdtPeriod = WDT_W'(WDT_PER_220);
    endcase
  endfunction

  logic             req;
  logic             wrOpt;
  logic             wrFlg;
  logic [REG_W-1:0] rdByte;
  logic [REG_W-1:0] setVec;
  logic [REG_W-1:0] clrVec;
  logic [REG_W-1:0] flagNext;
  logic [1:0]       adcSel;
  logic [1:0]       wdtSelOpt;
  logic             maskActive;
  logic             wdtReload;

  assign req        = wbReq.cyc && wbReq.stb;
  // Writes land at the edge where the master samples ack
  assign wrOpt      = req && s_q.ackQ && wbReq.we && wbReq.sel[0] && isReg(wbReq.adr, OPTION_IDX);
  assign wrFlg      = req && s_q.ackQ && wbReq.we && wbReq.sel[0] && isReg(wbReq.adr, FLAGS_IDX);
  assign adcSel     = s_q.option[OPT_ADC_LSB +: 2];
  assign wdtSelOpt  = s_q.option[OPT_WDT_LSB +: 2];
  assign maskActive = pwmIn.forceClear && pwmIn.maskEnable;
  assign wdtReload  = wdtClear || (s_q.wdtCnt == '0);

  always_comb
  begin
    setVec          = '0;
    setVec[FLG_LV]  = s_q.lvSync;             // RQ5
    setVec[FLG_MEM] = flagSrc.memWriteDone;   // RQ7
    setVec[FLG_ADC] = flagSrc.adcDone;        // RQ9
    setVec[FLG_PIN] = flagSrc.pinChangeSet;   // RQ11
    setVec[FLG_T3]  = flagSrc.timerThreeSet;  // RQ13
    clrVec          = wrFlg ? (~wbReq.dat[REG_W-1:0] & FLG_WRITABLE) : '0; // RQ16
    clrVec[FLG_ADC] = clrVec[FLG_ADC] || flagSrc.adcStartConversion;      // RQ10
    clrVec[FLG_MEM] = clrVec[FLG_MEM] || flagSrc.memIsrEnter;             // RQ15
  end

  for (genvar i = 0; i < REG_W; i++)
  begin : g_flag
    if (FLG_WRITABLE[i])
    begin : g_sticky
      // Set wins over a clear in the same cycle, so a low supply holds bit 7
      assign flagNext[i] = setVec[i] || (s_q.flags[i] && !clrVec[i]); // RQ16 RQ6 RQ17
    end
    else if (i == FLG_BUSY)
    begin : g_busy
      assign flagNext[i] = flagSrc.memWriteBusy; // RQ8
    end
    else
    begin : g_zero
      assign flagNext[i] = 1'b0;
    end
  end

  always_comb
  begin
    rdByte = '0;
    if (isReg(wbReq.adr, OPTION_IDX))
    begin
      rdByte = s_q.option;
    end
    else if (isReg(wbReq.adr, FLAGS_IDX))
    begin
      rdByte = s_q.flags; // RQ17
    end
  end

  always_comb
  begin
    s_d = s_q;
    // One-cycle answer; unmapped addresses ack with zero data
    s_d.ackQ = req && !s_q.ackQ;
    s_d.datO = (req && !s_q.ackQ && !wbReq.we) ? {{(DAT_W-REG_W){1'b0}}, rdByte} : '0;
    if (wrOpt)
    begin
      s_d.option = wbReq.dat[REG_W-1:0] & OPTION_MASK;
    end
    s_d.flags  = flagNext;
    s_d.pinClr = wrFlg && !wbReq.dat[FLG_PIN]; // RQ12
    // Analogue detector output is asynchronous
    s_d.lvMeta = flagSrc.lowVoltage;
    s_d.lvSync = s_q.lvMeta;
    // Divisor is taken at reload so a mid-period write cannot shorten a cycle
    if (s_q.adcCnt == '0)
    begin
      s_d.adcCnt  = 5'(adcDivisor(adcSel) - 6'h01); // RQ1
      s_d.adcTick = 1'b1;
    end
    else
    begin
      s_d.adcCnt  = s_q.adcCnt - 5'h01;
      s_d.adcTick = 1'b0;
    end
    if (wdtReload)
    begin
      s_d.wdtCnt = wdtPeriod(wdtSelOpt) - WDT_W'(1); // RQ4 RQ14
      s_d.wdtSel = wdtSelOpt;
    end
    else
    begin
      s_d.wdtCnt = s_q.wdtCnt - WDT_W'(1);
    end
    s_d.wdtOvf = !wdtClear && (s_q.wdtCnt == '0);
    s_d.pwmPos = maskActive ? s_q.option[OPT_POS_BIT] : pwmIn.pos; // RQ3
    s_d.pwmNeg = maskActive ? s_q.option[OPT_NEG_BIT] : pwmIn.neg; // RQ2
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_q        <= '0;
      s_q.option <= OPTION_RST;
      s_q.flags  <= FLAGS_RST;
      s_q.wdtCnt <= WDT_W'(WDT_PER_220 - 1);
      s_q.wdtSel <= WDT_SEL_220;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wbAck             = s_q.ackQ;
  assign wbDatO            = s_q.datO;
  assign adcClkTick        = s_q.adcTick;
  assign watchdogOverflow  = s_q.wdtOvf;
  assign pwmPositiveOutput = s_q.pwmPos;
  assign pwmNegativeOutput = s_q.pwmNeg;
  assign interruptFlags    = s_q.flags;
  assign pinFlagsClear     = s_q.pinClr;

  // Checking helpers
  logic [WDT_W-1:0] wdtSince_q;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wdtSince_q <= '0;
    end
    else
    begin
      wdtSince_q <= wdtReload ? '0 : wdtSince_q + WDT_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_adc_div_three: assert property ( // RQ1
    s_q.adcCnt == '0 && adcSel == ADC_SEL_3 |=> adcClkTick ##1 !adcClkTick [*2] ##1 adcClkTick)
    else $error("ADC divide by 3 period wrong");
  a_adc_div_four: assert property ( // RQ1
    s_q.adcCnt == '0 && adcSel == ADC_SEL_4 |=> adcClkTick ##1 !adcClkTick [*3] ##1 adcClkTick)
    else $error("ADC divide by 4 period wrong");
  a_pwm_neg_mask: assert property ( // RQ2
    maskActive |=> pwmNegativeOutput == $past(s_q.option[OPT_NEG_BIT]))
    else $error("negative PWM output not masked");
  a_pwm_pos_mask: assert property ( // RQ3
    maskActive |=> pwmPositiveOutput == $past(s_q.option[OPT_POS_BIT]))
    else $error("positive PWM output not masked");
  a_wdt_period_27: assert property ( // RQ4
    s_q.wdtCnt == '0 && !wdtClear && s_q.wdtSel == WDT_SEL_27
    |-> wdtSince_q == WDT_W'(WDT_PER_27 - 1) ##1 watchdogOverflow)
    else $error("27 ms watchdog period wrong");
  a_wdt_period_220: assert property ( // RQ14
    s_q.wdtCnt == '0 && !wdtClear && s_q.wdtSel == WDT_SEL_220
    |-> wdtSince_q == WDT_W'(WDT_PER_220 - 1))
    else $error("220 ms watchdog period wrong");
  a_lv_flag_set: assert property ( // RQ5
    s_q.lvSync |=> interruptFlags[FLG_LV])
    else $error("low-voltage flag not set");
  a_lv_clear_held: assert property ( // RQ6
    wrFlg && !wbReq.dat[FLG_LV] && s_q.lvSync |=> interruptFlags[FLG_LV])
    else $error("low-voltage flag cleared during low supply");
  a_mem_done_set: assert property ( // RQ7
    flagSrc.memWriteDone |=> interruptFlags[FLG_MEM])
    else $error("write-done flag not set");
  a_busy_follows: assert property ( // RQ8
    ##1 interruptFlags[FLG_BUSY] == $past(flagSrc.memWriteBusy))
    else $error("busy bit does not follow write");
  a_adc_done_set: assert property ( // RQ9
    flagSrc.adcDone |=> interruptFlags[FLG_ADC])
    else $error("ADC done flag not set");
  a_adc_start_clr: assert property ( // RQ10
    flagSrc.adcStartConversion && !flagSrc.adcDone |=> !interruptFlags[FLG_ADC])
    else $error("start conversion did not clear ADC done");
  a_pin_clear_all: assert property ( // RQ12
    wrFlg && !wbReq.dat[FLG_PIN] && !flagSrc.pinChangeSet
    |=> pinFlagsClear && !interruptFlags[FLG_PIN] ##1 !pinFlagsClear)
    else $error("pin-change clear incomplete");
  a_timer_set: assert property ( // RQ13
    flagSrc.timerThreeSet |=> interruptFlags[FLG_T3])
    else $error("timer three flag not set");
  a_mem_isr_clr: assert property ( // RQ15
    flagSrc.memIsrEnter && !flagSrc.memWriteDone |=> !interruptFlags[FLG_MEM])
    else $error("ISR entry did not clear write-done");
  a_flag_sticky: assert property ( // RQ17
    interruptFlags[FLG_T3] && !wrFlg [*2] |-> ##1 interruptFlags[FLG_T3])
    else $error("timer flag dropped without clear");
  a_write_one_keeps: assert property ( // RQ16
    wrFlg && wbReq.dat[FLG_ADC] && interruptFlags[FLG_ADC] && !flagSrc.adcStartConversion
    |=> interruptFlags[FLG_ADC])
    else $error("writing one changed a flag");

  // Bus answer shape: one-cycle ack, read data zero outside it
  a_ack_single: assert property ( // RQ17
    wbAck |=> !wbAck)
    else $error("ack held for more than one cycle");
  a_idle_data_zero: assert property ( // RQ17
    !wbAck |-> wbDatO == '0)
    else $error("read data driven without ack");
  a_unused_bits_zero: assert property ( // RQ17
    (interruptFlags & ~(FLG_WRITABLE | (REG_W'(1) << FLG_BUSY))) == '0)
    else $error("unused flag bit set");
  a_adc_div_32: assert property ( // RQ1
    s_q.adcCnt == '0 && adcSel == ADC_SEL_32 |=> adcClkTick ##1 !adcClkTick ##31 adcClkTick)
    else $error("ADC divide by 32 period wrong");
  a_wdt_period_110: assert property ( // RQ14
    s_q.wdtCnt == '0 && !wdtClear && s_q.wdtSel == WDT_SEL_110
    |-> wdtSince_q == WDT_W'(WDT_PER_110 - 1))
    else $error("110 ms watchdog period wrong");
  a_wdt_period_54: assert property ( // RQ14
    s_q.wdtCnt == '0 && !wdtClear && s_q.wdtSel == WDT_SEL_54
    |-> wdtSince_q == WDT_W'(WDT_PER_54 - 1))
    else $error("54 ms watchdog period wrong");
  a_wdt_clear_quiet: assert property ( // RQ4
    wdtClear |=> !watchdogOverflow)
    else $error("overflow issued in a clear cycle");
  a_pin_flag_set: assert property ( // RQ11
    flagSrc.pinChangeSet |=> interruptFlags[FLG_PIN])
    else $error("pin-change flag not set");
  a_pin_clr_source: assert property ( // RQ12
    !(wrFlg && !wbReq.dat[FLG_PIN]) |=> !pinFlagsClear)
    else $error("pin flag clear pulse without write");
  // Set and clear in one cycle: the event must survive
  a_set_beats_clear: assert property ( // RQ16
    wrFlg && !wbReq.dat[FLG_T3] && flagSrc.timerThreeSet |=> interruptFlags[FLG_T3])
    else $error("clear overrode a hardware set");
  a_adc_flag_holds: assert property ( // RQ17
    interruptFlags[FLG_ADC] && !wrFlg && !flagSrc.adcStartConversion |=> interruptFlags[FLG_ADC])
    else $error("ADC done flag dropped without clear");
  a_pin_flag_holds: assert property ( // RQ17
    interruptFlags[FLG_PIN] && !wrFlg |=> interruptFlags[FLG_PIN])
    else $error("pin-change flag dropped without clear");

  c_adc_tick: cover property (adcClkTick);
  c_wdt_overflow: cover property (watchdogOverflow);
  c_lv_cleared: cover property (wrFlg && !wbReq.dat[FLG_LV] ##1 !interruptFlags[FLG_LV]);
  c_pin_clear: cover property (pinFlagsClear);
  c_flag_read: cover property (wbAck && isReg(wbReq.adr, FLAGS_IDX) && wbDatO != '0);

endmodule
`default_nettype wire

// file: rtl/irq_flag_option_pkg.sv
// Constants and carrier types for the interrupt flag and option register bank.
// Assumes a 100 MHz system clock and a classic Wishbone master with 32-bit data.
`default_nettype none
package irq_flag_option_pkg;

  // Bus shape; registers sit at byte address = 4 * index
  localparam int         ADR_W      = 10;
  localparam int         DAT_W      = 32;
  localparam int         SEL_W      = 4;
  localparam int         REG_W      = 8;
  localparam logic [7:0] OPTION_IDX = 8'h94;
  localparam logic [7:0] FLAGS_IDX  = 8'h95;

  // option_control fields
  localparam int OPT_WDT_LSB = 4;
  localparam int OPT_ADC_LSB = 2;
  localparam int OPT_NEG_BIT = 1;
  localparam int OPT_POS_BIT = 0;
  localparam logic [REG_W-1:0] OPTION_MASK = 8'h3F;
  localparam logic [REG_W-1:0] OPTION_RST  = 8'h00;

  // interrupt_flags fields
  localparam int FLG_LV   = 7;
  localparam int FLG_MEM  = 6;
  localparam int FLG_BUSY = 5;
  localparam int FLG_ADC  = 4;
  localparam int FLG_PIN  = 1;
  localparam int FLG_T3   = 0;
  localparam logic [REG_W-1:0] FLG_WRITABLE = 8'hD3;
  localparam logic [REG_W-1:0] FLAGS_RST    = 8'h00;

  // ADC clock select codes and divisors
  localparam logic [1:0] ADC_SEL_32  = 2'h0;
  localparam logic [1:0] ADC_SEL_3   = 2'h1;
  localparam logic [1:0] ADC_SEL_4   = 2'h3;
  localparam logic [5:0] ADC_DIV_32  = 6'h20;
  localparam logic [5:0] ADC_DIV_3   = 6'h03;
  localparam logic [5:0] ADC_DIV_4   = 6'h04;

  // Watchdog period select codes and overflow times
  localparam logic [1:0] WDT_SEL_220 = 2'h0;
  localparam logic [1:0] WDT_SEL_110 = 2'h1;
  localparam logic [1:0] WDT_SEL_54  = 2'h2;
  localparam logic [1:0] WDT_SEL_27  = 2'h3;
  localparam int CLK_HZ       = 100_000_000;
  localparam int WDT_MS_220   = 220;
  localparam int WDT_MS_110   = 110;
  localparam int WDT_MS_54    = 54;
  localparam int WDT_MS_27    = 27;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int WDT_CYC_220  = WDT_MS_220 * CYC_PER_MS;
  localparam int WDT_CYC_110  = WDT_MS_110 * CYC_PER_MS;
  localparam int WDT_CYC_54   = WDT_MS_54 * CYC_PER_MS;
  localparam int WDT_CYC_27   = WDT_MS_27 * CYC_PER_MS;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic forceClear;
    logic maskEnable;
    logic pos;
    logic neg;
  } pwm_in_t;

  typedef struct packed {
    logic lowVoltage;
    logic memWriteDone;
    logic memWriteBusy;
    logic memIsrEnter;
    logic adcDone;
    logic adcStartConversion;
    logic pinChangeSet;
    logic timerThreeSet;
  } flag_src_t;

endpackage
`default_nettype wire

// file: sim/flag_source_model.sv
// Stand-in for the peripherals that raise flag events.
// Assumes the bench requests events on clk; each one reaches the block a cycle later.
`timescale 1ns/1ns
`default_nettype none
module flag_source_model
  import irq_flag_option_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       lowSupply,
  input  wire logic [6:0] eventReq,
  output var flag_src_t   flagSrc
);
  // Registered so every event, supply level included, launches off a clean edge
  always_ff @(posedge clk)
  begin
    if (!nrst)
      flagSrc <= '0;
    else
      flagSrc <= flag_src_t'({lowSupply, eventReq});
  end
endmodule
`default_nettype wire

// file: sim/interrupt_flag_and_option_bank_tb_top.sv
// Self-checking bench for the interrupt flag and option bank.
// Assumes the source model in flag_source_model.sv and short watchdog periods.
`timescale 1ns/1ns
`default_nettype none
`define CHK(act, exp) \
  begin \
    totalChecks++; \
    if ((act) !== (exp)) \
    begin \
      mismatches++; \
      $display("[ERR] t=%0t act=%0h exp=%0h", $time, (act), (exp)); \
    end \
  end
module interrupt_flag_and_option_bank_tb_top
  import irq_flag_option_pkg::*;
;
  localparam logic [ADR_W-1:0] A_OPT = {OPTION_IDX, 2'h0};
  localparam logic [ADR_W-1:0] A_FLG = {FLAGS_IDX, 2'h0};
  localparam logic [ADR_W-1:0] A_BAD = 10'h258;
  localparam logic [6:0] E_MEM = 7'h40;
  localparam logic [6:0] E_BUSY = 7'h20;
  localparam logic [6:0] E_ISR = 7'h10;
  localparam logic [6:0] E_ADC = 7'h08;
  localparam logic [6:0] E_SOC = 7'h04;
  localparam logic [6:0] E_PIN = 7'h02;
  localparam logic [6:0] E_T3 = 7'h01;

  logic             clk;
  logic             nrst;
  wb_req_t          wbReq;
  logic             wbAck;
  logic [DAT_W-1:0] wbDatO;
  flag_src_t        flagSrc;
  pwm_in_t          pwmIn;
  logic             wdtClear;
  logic             adcClkTick;
  logic             wdOver;
  logic             pwmPos;
  logic             pwmNeg;
  logic [REG_W-1:0] flags;
  logic             pinFlagsClear;
  logic             lowSupply;
  logic [6:0]       eventReq;
  logic [7:0]       rd;
  int               mismatches;
  int               totalChecks;

  interrupt_flag_and_option_bank #(.WDT_PER_220(80), .WDT_PER_110(40), .WDT_PER_54(20), .WDT_PER_27(10))
    i_interrupt_flag_and_option_bank (.clk(clk), .nrst(nrst), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
    .flagSrc(flagSrc), .pwmIn(pwmIn), .wdtClear(wdtClear), .adcClkTick(adcClkTick),
    .watchdogOverflow(wdOver), .pwmPositiveOutput(pwmPos), .pwmNegativeOutput(pwmNeg),
    .interruptFlags(flags), .pinFlagsClear(pinFlagsClear));

  flag_source_model i_flag_source_model (.clk(clk), .nrst(nrst), .lowSupply(lowSupply), .eventReq(eventReq),
    .flagSrc(flagSrc));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One classic cycle; entered just after an edge, returns one edge after the release
  task automatic wbAcc(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d, output logic [7:0] r,
                       input logic [SEL_W-1:0] s = 4'hF);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'h1, stb: 1'h1, we: w, adr: a, sel: s, dat: {24'h0, d}};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'h1 && n < 50);
    // A request that is never answered counts against the run
    `CHK(wbAck, 1'h1)
    r = wbDatO[7:0];
    wbReq <= '0;
    @(posedge clk);
  endtask

  task automatic fire(input logic [6:0] m);
    eventReq <= m;
    @(posedge clk);
    eventReq <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_regs();
    wbAcc(1'h0, A_OPT, 8'h00, rd);
    `CHK(rd, OPTION_RST)
    wbAcc(1'h0, A_FLG, 8'h00, rd);
    `CHK(rd, FLAGS_RST)
    wbAcc(1'h1, A_OPT, 8'hFF, rd);
    wbAcc(1'h1, A_BAD, 8'h00, rd);
    wbAcc(1'h0, A_OPT, 8'h00, rd);
    `CHK(rd, OPTION_MASK)
    wbAcc(1'h0, A_BAD, 8'h00, rd);
    `CHK(rd, 8'h00)
    // Lane 0 disabled: the write is acked but ignored
    wbAcc(1'h1, A_OPT, 8'h00, rd, 4'hE);
    wbAcc(1'h0, A_OPT, 8'h00, rd);
    `CHK(rd, OPTION_MASK)
    wbAcc(1'h1, A_OPT, 8'h00, rd);
    $display("regs done");
  endtask

  task automatic t_flags();
    fire(E_MEM | E_ADC | E_PIN | E_T3);
    `CHK(flags, 8'h53)
    wbAcc(1'h0, A_FLG, 8'h00, rd);
    `CHK(rd, 8'h53)
    wbAcc(1'h1, A_FLG, 8'hEF, rd);
    `CHK(flags, 8'h43)
    wbAcc(1'h1, A_FLG, 8'hFD, rd);
    `CHK(pinFlagsClear, 1'h1)
    `CHK(flags, 8'h41)
    wbAcc(1'h1, A_FLG, 8'hFE, rd);
    `CHK(flags, 8'h40)
    fire(E_ISR);
    `CHK(flags, 8'h00)
    fire(E_ADC);
    fire(E_SOC);
    `CHK(flags, 8'h00)
    eventReq <= E_BUSY;
    repeat (4) @(posedge clk);
    `CHK(flags, 8'h20)
    wbAcc(1'h1, A_FLG, 8'h00, rd);
    `CHK(flags, 8'h20)
    eventReq <= '0;
    repeat (4) @(posedge clk);
    `CHK(flags, 8'h00)
    $display("flags done");
  endtask

  task automatic t_lv();
    lowSupply <= 1'h1;
    repeat (6) @(posedge clk);
    `CHK(flags, 8'h80)
    wbAcc(1'h1, A_FLG, 8'h7F, rd);
    `CHK(flags, 8'h80)
    lowSupply <= 1'h0;
    repeat (6) @(posedge clk);
    wbAcc(1'h1, A_FLG, 8'h7F, rd);
    `CHK(flags, 8'h00)
    $display("low voltage done");
  endtask

  task automatic t_pwm();
    wbAcc(1'h1, A_OPT, 8'h01, rd);
    pwmIn <= '{forceClear: 1'h1, maskEnable: 1'h1, pos: 1'h0, neg: 1'h1};
    repeat (2) @(posedge clk);
    `CHK(pwmPos, 1'h1)
    `CHK(pwmNeg, 1'h0)
    wbAcc(1'h1, A_OPT, 8'h02, rd);
    @(posedge clk);
    `CHK(pwmPos, 1'h0)
    `CHK(pwmNeg, 1'h1)
    pwmIn <= '{forceClear: 1'h1, maskEnable: 1'h0, pos: 1'h1, neg: 1'h0};
    repeat (2) @(posedge clk);
    `CHK(pwmPos, 1'h1)
    `CHK(pwmNeg, 1'h0)
    $display("pwm done");
  endtask

  // New selects load at the next reload, so only the third interval is judged
  task automatic t_period(input logic [7:0] opt, input int exp, input logic wd);
    int n;
    wbAcc(1'h1, A_OPT, opt, rd);
    if (wd)
    begin
      wdtClear <= 1'h1;
      @(posedge clk);
      wdtClear <= 1'h0;
    end
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while ((wd ? wdOver : adcClkTick) !== 1'h1 && n < 300);
      `CHK((n < 300), 1'h1)
    end
    `CHK(n, exp)
    $display("period %0h done", opt);
  endtask

  // A second reset in mid-run must restore the option byte and drop held flags
  task automatic t_reset();
    wbAcc(1'h1, A_OPT, 8'h3F, rd);
    fire(E_T3 | E_MEM);
    `CHK(flags, 8'h41)
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    `CHK(flags, FLAGS_RST)
    wbAcc(1'h0, A_OPT, 8'h00, rd);
    `CHK(rd, OPTION_RST)
    $display("reset done");
  endtask

  initial
  begin
    nrst = 1'h0;
    wbReq = '0;
    pwmIn = '0;
    wdtClear = 1'h0;
    lowSupply = 1'h0;
    eventReq = '0;
    mismatches = 0;
    totalChecks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_regs();
    t_flags();
    t_lv();
    t_pwm();
    t_period(8'h00, 32, 1'h0);
    t_period(8'h04, 3, 1'h0);
    t_period(8'h0C, 4, 1'h0);
    t_period(8'h08, 32, 1'h0);
    t_period(8'h00, 80, 1'h1);
    t_period(8'h10, 40, 1'h1);
    t_period(8'h20, 20, 1'h1);
    t_period(8'h30, 10, 1'h1);
    t_reset();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
